// ---- t2crb_core_model.sv ----
// Far-side model: timer 1 overflow source and tallies of baud ticks.
// Assumes the same bus clock and synchronous reset as the timer block.
`timescale 1ns/1ps
`default_nettype none
module t2crb_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Baud ticks from the timer
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  // Timer 1 source and tallies
  output logic timer1_overflow,
  output logic [15:0] n_rx,
  output logic [15:0] n_tx,
  output logic [15:0] n_t1
);
  logic [2:0] div;
  // Timer 1 overflows every 5 clocks; tallies share one process so they stay coherent
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      div <= 3'h0;
      timer1_overflow <= 1'b0;
      n_rx <= 16'h0000;
      n_tx <= 16'h0000;
      n_t1 <= 16'h0000;
    end else begin
      div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
      timer1_overflow <= (div == 3'h4);
      n_t1 <= n_t1 + {15'h0000, timer1_overflow};
      n_rx <= n_rx + {15'h0000, rx_baud_tick};
      n_tx <= n_tx + {15'h0000, tx_baud_tick};
    end
  end
endmodule
`default_nettype wire

// ---- t2crb_edge.sv ----
// Two-stage synchroniser with falling edge detection.
// Assumes the input is a slow level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module t2crb_edge (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin and results
  input wire logic pin_in,
  output logic level,
  output logic fall
);

  logic meta_ff, sync_ff, prev_ff;
  logic nxt_meta, nxt_sync, nxt_prev;

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  always_comb begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // Only the second and third stages feed the compare
  assign level = sync_ff;
  assign fall = prev_ff & ~sync_ff;

endmodule
`default_nettype wire

// ---- t2crb_pkg.sv ----
// Constants for the 16-bit capture/reload/baud timer block.
// Assumes a 32-bit Avalon-MM register bus with one register per word.
package t2crb_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_MODE = 8'hC9;
  localparam logic [7:0] IDX_CAP_LOW = 8'hCA;
  localparam logic [7:0] IDX_CAP_HIGH = 8'hCB;
  localparam logic [7:0] IDX_COUNT_LOW = 8'hCC;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] IDX_CLOCK_SEL = 8'hCE;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_OVERFLOW = 7;
  localparam int CTL_EXT_FLAG = 6;
  localparam int CTL_RX_BAUD = 5;
  localparam int CTL_TX_BAUD = 4;
  localparam int CTL_TRIG_EN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_COUNT_SRC = 1;
  localparam int CTL_CAP_RELOAD = 0;

  // Mode and clock select fields
  localparam int MODE_DOWN_EN = 0;
  localparam int CLK_PRESCALE = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'hFE;
  localparam logic [7:0] RST_CAP = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CLOCK_SEL = 8'h00;

  // ----------------------------------------
  // Timing counts: prescale dividers in bus clocks, baud overflow divider and count limit
  // ----------------------------------------
  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_BAUD = 4'h2;
  localparam logic [3:0] BAUD_OVF_DIV = 4'hF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Bus read handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } t2crb_bus_t;

endpackage

// ---- t2crb_presc.sv ----
// Count tick prescaler: divides the bus clock by 12, 4 or 2.
// Assumes the select inputs are register outputs in the same domain.
`timescale 1ns/1ps
`default_nettype none
module t2crb_presc (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Rate selection
  input wire logic fast_sel,
  input wire logic baud_mode,
  // Tick out
  output logic tick
);

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] limit;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    if (baud_mode) begin
      limit = t2crb_pkg::DIV_BAUD - 4'h1;
    end else if (fast_sel) begin
      limit = t2crb_pkg::DIV_FAST - 4'h1;
    end else begin
      limit = t2crb_pkg::DIV_SLOW - 4'h1;
    end
    // Wrap early if the rate shrinks mid-count
    tick = (cnt_ff >= limit);
    nxt_cnt = tick ? 4'h0 : cnt_ff + 4'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule
`default_nettype wire

// ---- t2crb_props.sv ----
// Checker for the timer block: bus handshake, flags, interrupt and baud outputs.
// Assumes it is bound to t2crb_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module t2crb_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Core and serial side
  input wire logic irq_enable,
  input wire logic overflow_flag,
  input wire logic external_event_flag,
  input wire logic timer_irq,
  input wire logic timer1_overflow,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick
);
  // ----------------------------------------
  // Shadow of the baud select bits
  // ----------------------------------------
  logic ctl_wr;
  logic rx_sel_ff, tx_sel_ff, nxt_rx_sel, nxt_tx_sel;
  assign ctl_wr = avs_write && avs_byteenable[0] && (avs_address[9:2] == t2crb_pkg::IDX_CONTROL);
  always_comb begin
    nxt_rx_sel = ctl_wr ? avs_writedata[t2crb_pkg::CTL_RX_BAUD] : rx_sel_ff;
    nxt_tx_sel = ctl_wr ? avs_writedata[t2crb_pkg::CTL_TX_BAUD] : tx_sel_ff;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_sel_ff <= 1'b0;
      tx_sel_ff <= 1'b0;
    end else begin
      rx_sel_ff <= nxt_rx_sel;
      tx_sel_ff <= nxt_tx_sel;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_irq_follows_flags: assert property (timer_irq == (irq_enable && (overflow_flag || external_event_flag)))
    else $error("interrupt does not follow flags");
  a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_ovf_flag_sticky: assert property (overflow_flag && !ctl_wr |=> overflow_flag)
    else $error("overflow flag dropped by hardware");
  a_ext_flag_sticky: assert property (external_event_flag && !ctl_wr |=> external_event_flag)
    else $error("external flag dropped by hardware");
  a_sw_sets_ovf: assert property (ctl_wr && avs_writedata[7] |=> overflow_flag)
    else $error("software set of overflow flag lost");
  a_no_ovf_baud: assert property ((rx_sel_ff || tx_sel_ff) && !ctl_wr |=> !$rose(overflow_flag))
    else $error("overflow flag set in baud mode");
  a_rx_from_t1: assert property (!rx_sel_ff |-> rx_baud_tick == timer1_overflow)
    else $error("receive tick not from timer 1");
  a_tx_from_t1: assert property (!tx_sel_ff |-> tx_baud_tick == timer1_overflow)
    else $error("transmit tick not from timer 1");
  a_reset_clears: assert property ($rose(rst_n) |-> !overflow_flag && !external_event_flag)
    else $error("flags not cleared by reset");
  a_baud_tick_spaced: assert property (rx_sel_ff && rx_baud_tick && !ctl_wr |=> !rx_baud_tick)
    else $error("baud ticks too close");
  c_irq: cover property (timer_irq);
  c_baud_tick: cover property (rx_sel_ff && rx_baud_tick);
  c_ext_edge: cover property ($rose(external_event_flag));
endmodule
bind t2crb_top t2crb_props u_props (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_enable, .overflow_flag, .external_event_flag,
  .timer_irq, .timer1_overflow, .rx_baud_tick, .tx_baud_tick);
`default_nettype wire

// ---- t2crb_tb_top.sv ----
// Self-checking bench for the timer block through its register bus.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module t2crb_tb_top;
  localparam logic [7:0] CTL = t2crb_pkg::IDX_CONTROL;
  localparam logic [7:0] CAPL = t2crb_pkg::IDX_CAP_LOW;
  localparam logic [7:0] CAPH = t2crb_pkg::IDX_CAP_HIGH;
  localparam logic [7:0] CNTL = t2crb_pkg::IDX_COUNT_LOW;
  localparam logic [7:0] CNTH = t2crb_pkg::IDX_COUNT_HIGH;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, trig, cnt, irq_enable;
  logic ovf, ext, irq, t1, rx, tx;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] n_rx, n_tx, n_t1;
  logic [7:0] b_rx, b_tx;
  int errors, n_compared, cyc, i;
  t2crb_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_trigger_input(trig), .external_count_input(cnt),
    .irq_enable(irq_enable), .overflow_flag(ovf), .external_event_flag(ext), .timer_irq(irq),
    .timer1_overflow(t1), .rx_baud_tick(rx), .tx_baud_tick(tx));
  t2crb_core_model partner (.ref_clk(ref_clk), .rst_n(rst_n), .rx_baud_tick(rx), .tx_baud_tick(tx),
    .timer1_overflow(t1), .n_rx(n_rx), .n_tx(n_tx), .n_t1(n_t1));
  always #10 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Bus access and comparison
  // ----------------------------------------
  task automatic acc(input logic rd, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_read <= rd;
    avs_write <= !rd;
    // Request stands until the rising edge that sees waitrequest low; data is taken there
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, idx, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b1, idx, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic wait_ovf();
    for (int k = 0; k < 200 && ovf !== 1'b1; k++) @(posedge ref_clk);
  endtask
  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0; rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 10'h000;
    avs_writedata = 32'h00000000; trig = 1'b1; cnt = 1'b1; irq_enable = 1'b0;
    errors = 0; n_compared = 0; cyc = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd_chk(CTL, 8'h00);
    rd_chk(t2crb_pkg::IDX_MODE, 8'hFE);
    rd_chk(CAPL, 8'h00);
    rd_chk(CAPH, 8'h00);
    rd_chk(CNTL, 8'h00);
    rd_chk(CNTH, 8'h00);
    rd_chk(8'h10, 8'h00);
    chk(n_rx[7:0], n_t1[7:0]);
    chk(n_tx[7:0], n_t1[7:0]);
    wr(CAPL, 8'hA5);
    rd_chk(CAPL, 8'hA5);
    // Trigger ignored while disabled, then captured
    wr(CNTL, 8'h34);
    wr(CNTH, 8'h12);
    wr(CTL, 8'h01);
    trig <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({7'h00, ext}, 8'h00);
    trig <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(CTL, 8'h09);
    irq_enable <= 1'b1;
    trig <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd_chk(CAPL, 8'h34);
    rd_chk(CAPH, 8'h12);
    chk({7'h00, ext}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rd_chk(CNTL, 8'h34);
    wr(CTL, 8'h00);
    chk({7'h00, irq}, 8'h00);
    trig <= 1'b1;
    // Trigger fall reloads the count
    wr(CAPL, 8'hCD);
    wr(CAPH, 8'hAB);
    wr(CTL, 8'h08);
    trig <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd_chk(CNTL, 8'hCD);
    rd_chk(CNTH, 8'hAB);
    chk({7'h00, ext}, 8'h01);
    trig <= 1'b1;
    // Clear first so only the software write can raise the request
    wr(CTL, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(CTL, 8'h40);
    chk({7'h00, irq}, 8'h01);
    wr(CTL, 8'h00);
    // Tick rate over a 120 clock run window, slow then fast prescale
    for (i = 0; i < 2; i++) begin
      wr(CNTL, 8'h00);
      wr(CNTH, 8'h00);
      wr(t2crb_pkg::IDX_CLOCK_SEL, i[7:0]);
      wr(CTL, 8'h04);
      repeat (118) @(posedge ref_clk);
      wr(CTL, 8'h00);
      repeat (30) @(posedge ref_clk);
      rd_chk(CNTL, (i == 0) ? 8'h0A : 8'h1E);
    end
    // Counter mode counts pin falls
    wr(CNTL, 8'h00);
    wr(CTL, 8'h06);
    repeat (5) begin
      cnt <= 1'b0;
      repeat (4) @(posedge ref_clk);
      cnt <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    wr(CTL, 8'h00);
    rd_chk(CNTL, 8'h05);
    // Overflow reloads from the capture pair
    wr(CAPL, 8'h00);
    wr(CAPH, 8'h12);
    wr(CNTL, 8'hFE);
    wr(CNTH, 8'hFF);
    wr(CTL, 8'h04);
    wait_ovf();
    rd_chk(CTL, 8'h84);
    wr(CTL, 8'h00);
    chk({7'h00, ovf}, 8'h00);
    rd_chk(CNTH, 8'h12);
    // Down count to the reload value wraps to the top
    wr(t2crb_pkg::IDX_MODE, 8'hFF);
    trig <= 1'b0;
    wr(CAPH, 8'h00);
    wr(CNTL, 8'h03);
    wr(CNTH, 8'h00);
    wr(CTL, 8'h04);
    wait_ovf();
    chk({7'h00, ovf}, 8'h01);
    chk({7'h00, ext}, 8'h01);
    wr(CTL, 8'h00);
    rd_chk(CNTH, 8'hFF);
    wr(t2crb_pkg::IDX_MODE, 8'hFE);
    trig <= 1'b1;
    // Baud mode with reload FFFF gives one tick per 32 clocks
    wr(CAPL, 8'hFF);
    wr(CAPH, 8'hFF);
    wr(CTL, 8'h36);
    repeat (64) @(posedge ref_clk);
    b_rx = n_rx[7:0];
    b_tx = n_tx[7:0];
    repeat (320) @(posedge ref_clk);
    chk(n_rx[7:0] - b_rx, 8'h0A);
    chk(n_tx[7:0] - b_tx, 8'h0A);
    rd_chk(CTL, 8'h36);
    wr(CTL, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- t2crb_top.sv ----
// 16-bit timer/counter with capture, auto-reload and baud generation.
// Assumes an Avalon-MM master on the bus clock and asynchronous pins.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module t2crb_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins
  input wire logic external_trigger_input,
  input wire logic external_count_input,
  // Processor core
  input wire logic irq_enable,
  output logic overflow_flag,
  output logic external_event_flag,
  output logic timer_irq,
  // Serial port baud logic
  input wire logic timer1_overflow,
  output logic rx_baud_tick,
  output logic tx_baud_tick
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  t2crb_pkg::t2crb_bus_t bus_ff, nxt_bus;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] mode_ff, nxt_mode;
  logic [7:0] clksel_ff, nxt_clksel;
  logic [7:0] cap_lo_ff, nxt_cap_lo;
  logic [7:0] cap_hi_ff, nxt_cap_hi;
  logic [15:0] count_ff, nxt_count;
  logic [3:0] bdiv_ff, nxt_bdiv;
  logic [7:0] idx;
  logic wr_lane0;
  logic wr_ctrl, wr_mode, wr_clksel;
  logic wr_cap_lo, wr_cap_hi, wr_cnt_lo, wr_cnt_hi;
  logic trig_level, trig_fall, cnt_fall, presc_tick;
  logic rx_sel, tx_sel, baud_mode, run, trig_en;
  logic count_src, cap_mode, down_mode, count_up;
  logic tick, trig_event, wrap, match_down;
  logic set_ovf, set_ext, reload, capture;
  logic [15:0] reload_val;
  logic t2_baud;
  logic [7:0] rd_byte;

  // ----------------------------------------
  // Pin sampling and prescaler
  // ----------------------------------------
  t2crb_edge u_trig (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(external_trigger_input),
    .level(trig_level),
    .fall(trig_fall)
  );

  t2crb_edge u_cnt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(external_count_input),
    .level(),
    .fall(cnt_fall)
  );

  t2crb_presc u_presc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fast_sel(clksel_ff[t2crb_pkg::CLK_PRESCALE]),
    .baud_mode(baud_mode),
    .tick(presc_tick)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign rx_sel = ctrl_ff[t2crb_pkg::CTL_RX_BAUD];
  assign tx_sel = ctrl_ff[t2crb_pkg::CTL_TX_BAUD];
  assign run = ctrl_ff[t2crb_pkg::CTL_RUN];
  assign trig_en = ctrl_ff[t2crb_pkg::CTL_TRIG_EN];
  assign count_src = ctrl_ff[t2crb_pkg::CTL_COUNT_SRC];
  assign baud_mode = rx_sel | tx_sel;
  // Capture select has no effect while generating baud clocks
  assign cap_mode = ctrl_ff[t2crb_pkg::CTL_CAP_RELOAD] & ~baud_mode;
  // Up/down only applies in plain 16-bit auto-reload mode
  assign down_mode = mode_ff[t2crb_pkg::MODE_DOWN_EN] & ~cap_mode & ~baud_mode;
  assign count_up = ~down_mode | trig_level;
  assign reload_val = {cap_hi_ff, cap_lo_ff};

  // ----------------------------------------
  // Count engine
  // ----------------------------------------
  always_comb begin
    // Baud mode always uses the fast two-clock tick
    if (baud_mode) begin
      tick = run & presc_tick;
    end else if (count_src) begin
      tick = run & cnt_fall;
    end else begin
      tick = run & presc_tick;
    end
    // Trigger direction control consumes the pin in down mode
    trig_event = trig_fall & trig_en & ~baud_mode & ~down_mode;
    match_down = tick & ~count_up & (count_ff == reload_val);
    wrap = tick & count_up & (count_ff == t2crb_pkg::COUNT_MAX);
    capture = trig_event & cap_mode;
    reload = (wrap & ~cap_mode) | (trig_event & ~cap_mode);
    set_ovf = (wrap | match_down) & ~baud_mode;
    set_ext = trig_event | (down_mode & (wrap | match_down));
  end

  always_comb begin
    nxt_count = count_ff;
    if (reload) begin
      nxt_count = reload_val;
    end else if (match_down) begin
      nxt_count = t2crb_pkg::COUNT_MAX;
    end else if (tick) begin
      nxt_count = count_up ? count_ff + 16'h0001 : count_ff - 16'h0001;
    end
    // Software writes win over the counter in the same cycle
    if (wr_cnt_lo) begin
      nxt_count[7:0] = avs_writedata[7:0];
    end
    if (wr_cnt_hi) begin
      nxt_count[15:8] = avs_writedata[7:0];
    end
    // Clearing run stops ticks, but outside baud and down modes a trigger fall with CTL_TRIG_EN set still reloads the count, or captures it when CTL_CAP_RELOAD is set
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_ff <= {t2crb_pkg::RST_COUNT, t2crb_pkg::RST_COUNT};
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign idx = avs_address[9:2];
  assign wr_lane0 = avs_write & avs_byteenable[0];
  assign wr_ctrl = wr_lane0 & (idx == t2crb_pkg::IDX_CONTROL);
  assign wr_mode = wr_lane0 & (idx == t2crb_pkg::IDX_MODE);
  assign wr_cap_lo = wr_lane0 & (idx == t2crb_pkg::IDX_CAP_LOW);
  assign wr_cap_hi = wr_lane0 & (idx == t2crb_pkg::IDX_CAP_HIGH);
  assign wr_cnt_lo = wr_lane0 & (idx == t2crb_pkg::IDX_COUNT_LOW);
  assign wr_cnt_hi = wr_lane0 & (idx == t2crb_pkg::IDX_COUNT_HIGH);
  assign wr_clksel = wr_lane0 & (idx == t2crb_pkg::IDX_CLOCK_SEL);

  // ----------------------------------------
  // Control, mode and capture registers
  // ----------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    nxt_clksel = clksel_ff;
    nxt_cap_lo = cap_lo_ff;
    nxt_cap_hi = cap_hi_ff;
    if (wr_ctrl) begin
      nxt_ctrl = avs_writedata[7:0];
    end
    // A flag event in the write cycle still lands
    if (set_ovf) begin
      nxt_ctrl[t2crb_pkg::CTL_OVERFLOW] = 1'b1;
    end
    if (set_ext) begin
      nxt_ctrl[t2crb_pkg::CTL_EXT_FLAG] = 1'b1;
    end
    if (wr_mode) begin
      nxt_mode = avs_writedata[7:0];
    end
    if (wr_clksel) begin
      nxt_clksel = avs_writedata[7:0];
    end
    if (capture) begin
      nxt_cap_lo = count_ff[7:0];
      nxt_cap_hi = count_ff[15:8];
    end
    if (wr_cap_lo) begin
      nxt_cap_lo = avs_writedata[7:0];
    end
    if (wr_cap_hi) begin
      nxt_cap_hi = avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_ff <= t2crb_pkg::RST_CONTROL;
      mode_ff <= t2crb_pkg::RST_MODE;
      clksel_ff <= t2crb_pkg::RST_CLOCK_SEL;
      cap_lo_ff <= t2crb_pkg::RST_CAP;
      cap_hi_ff <= t2crb_pkg::RST_CAP;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
      clksel_ff <= nxt_clksel;
      cap_lo_ff <= nxt_cap_lo;
      cap_hi_ff <= nxt_cap_hi;
    end
  end

  // ----------------------------------------
  // Core flags and interrupt
  // ----------------------------------------
  assign overflow_flag = ctrl_ff[t2crb_pkg::CTL_OVERFLOW];
  assign external_event_flag = ctrl_ff[t2crb_pkg::CTL_EXT_FLAG];
  // A software-set external flag requests the interrupt like an edge
  assign timer_irq = irq_enable & (overflow_flag | external_event_flag);

  // ----------------------------------------
  // Baud output
  // ----------------------------------------
  // Overflow rate is F/(2*(65536-reload)); dividing by 16 gives F/(32*(65536-reload))
  always_comb begin
    nxt_bdiv = bdiv_ff;
    t2_baud = 1'b0;
    if (!baud_mode) begin
      nxt_bdiv = 4'h0;
    end else if (wrap) begin
      t2_baud = (bdiv_ff == t2crb_pkg::BAUD_OVF_DIV);
      nxt_bdiv = bdiv_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bdiv_ff <= 4'h0;
    end else begin
      bdiv_ff <= nxt_bdiv;
    end
  end

  assign rx_baud_tick = rx_sel ? t2_baud : timer1_overflow;
  assign tx_baud_tick = tx_sel ? t2_baud : timer1_overflow;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    case (idx)
      t2crb_pkg::IDX_CONTROL: rd_byte = ctrl_ff;
      t2crb_pkg::IDX_MODE: rd_byte = mode_ff;
      t2crb_pkg::IDX_CAP_LOW: rd_byte = cap_lo_ff;
      t2crb_pkg::IDX_CAP_HIGH: rd_byte = cap_hi_ff;
      t2crb_pkg::IDX_COUNT_LOW: rd_byte = count_ff[7:0];
      t2crb_pkg::IDX_COUNT_HIGH: rd_byte = count_ff[15:8];
      t2crb_pkg::IDX_CLOCK_SEL: rd_byte = clksel_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state lets read data come from a flip-flop
  always_comb begin
    nxt_bus = bus_ff;
    nxt_rdata = rdata_ff;
    case (bus_ff)
      t2crb_pkg::BUS_IDLE: begin
        if (avs_read) begin
          nxt_bus = t2crb_pkg::BUS_ACK;
          nxt_rdata = {24'h000000, rd_byte};
        end
      end
      t2crb_pkg::BUS_ACK: begin
        nxt_bus = t2crb_pkg::BUS_IDLE;
      end
      default: begin
        nxt_bus = t2crb_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_ff <= t2crb_pkg::BUS_IDLE;
      rdata_ff <= 32'h00000000;
    end else begin
      bus_ff <= nxt_bus;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = avs_read & (bus_ff != t2crb_pkg::BUS_ACK);

endmodule
`default_nettype wire
